// ==== pldmc_pkg.sv ====
// package: constants, types and helpers of the packet length and data mode control
package pldmc_pkg;
	// register map and reset values
	localparam logic [9:0]  CTRL_ADDR      = 10'h126;
	localparam logic [9:0]  MAXLEN_ADDR    = 10'h127;
	localparam logic [9:0]  RXLEN_ADDR     = 10'h3f0;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  MAXLEN_RESET   = 8'h00;
	// control register fields
	localparam int          BYTE_ORDER_BIT = 7;
	localparam int          FIXED_LEN_BIT  = 6;
	localparam int          CRC_EN_BIT     = 5;
	localparam int          PATH_HI        = 4;
	localparam int          PATH_LO        = 3;
	localparam int          OFS_HI         = 2;
	localparam logic [1:0]  PATH_PACKET    = 2'h0;
	localparam logic [1:0]  PATH_RAW_PRE   = 2'h1;
	localparam logic [1:0]  PATH_RAW_SYNC  = 2'h2;
	// length arithmetic and bit counts
	localparam logic [8:0]  PAYLOAD_BIAS   = 9'h004;
	localparam logic [4:0]  TX_BYTE_LEFT   = 5'h07;
	localparam logic [4:0]  TX_CRC_LEFT    = 5'h0f;
	localparam logic [3:0]  RX_BYTE_LAST   = 4'h7;
	localparam logic [3:0]  RX_CRC_LAST    = 4'hf;
	localparam logic [15:0] CRC_POLY       = 16'h1021;
	localparam logic [15:0] CRC_INIT       = 16'hffff;

	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CRC} pldmc_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_CRC} pldmc_rx_t;

	function automatic logic [15:0] pldmc_crc_step(input logic [15:0] crc, input logic bit_in);
		pldmc_crc_step = {crc[14:0], 1'b0} ^ (((crc[15] ^ bit_in) == 1'b1) ? CRC_POLY : 16'h0000);
	endfunction

	function automatic logic pldmc_first_bit(input logic [7:0] b, input logic msb_first);
		pldmc_first_bit = msb_first ? b[7] : b[0];
	endfunction

	function automatic logic [7:0] pldmc_shift_out(input logic [7:0] b, input logic msb_first);
		pldmc_shift_out = msb_first ? {b[6:0], 1'b0} : {1'b0, b[7:1]};
	endfunction

	function automatic logic [7:0] pldmc_shift_in(input logic [7:0] b, input logic d,
			input logic msb_first);
		pldmc_shift_in = msb_first ? {b[6:0], d} : {d, b[7:1]};
	endfunction

	// bytes to read after sync: length byte plus offset, capped at the maximum
	function automatic logic [7:0] pldmc_total(input logic [7:0] len, input logic [2:0] ofs,
			input logic [7:0] max_len);
		logic [8:0] sum;
		sum = {1'b0, len} + {6'h00, ofs};
		pldmc_total = (sum > {1'b0, max_len}) ? max_len : sum[7:0];
	endfunction

	// payload length, floored at zero
	function automatic logic [8:0] pldmc_payload(input logic [7:0] len, input logic [2:0] ofs);
		logic [8:0] sum;
		sum = {1'b0, len} + {6'h00, ofs};
		pldmc_payload = (sum >= PAYLOAD_BIAS) ? (sum - PAYLOAD_BIAS) : 9'h000;
	endfunction
endpackage

// ==== pldmc_fifo.sv ====
// transmit byte fifo with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none
module pldmc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	// fill side
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output var  logic             in_ready_out,
	// drain side
	output logic      [WIDTH-1:0] out_data_out,
	output var  logic             out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int         AW   = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_in_ready;
	logic             next_out_valid;
	logic             push;
	logic             pop;

	assign out_data_out = mem[rd_ptr];

	always_comb begin
		push           = in_valid_in && in_ready_out;
		pop            = out_ready_in && out_valid_out;
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + (AW + 1)'(push) - (AW + 1)'(pop);
		next_in_ready  = (next_count != FULL);
		next_out_valid = (next_count != '0);
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr        <= '0;
			rd_ptr        <= '0;
			count         <= '0;
			in_ready_out  <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			wr_ptr        <= next_wr_ptr;
			rd_ptr        <= next_rd_ptr;
			count         <= next_count;
			in_ready_out  <= next_in_ready;
			out_valid_out <= next_out_valid;
		end
	end

	// storage needs no reset; flags guard every read
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// ==== pldmc_framer.sv ====
// packet length, crc and data path control of the radio packet framer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: fixed mode uses maximum length both ways
// RULE2: variable receive length from first byte
// RULE3: variable transmit length from maximum register
// RULE4: crc enabled: append and check crc
// RULE5: crc disabled: no append, no check
// RULE6: path zero packet, otherwise raw serial
// RULE7: path one: interrupt on preamble detect
// RULE8: path two: interrupt on sync detect
// RULE9: offset added to received length byte
// RULE10: payload is length plus offset minus four
// RULE11: variable mode: maximum bounds receive length
// RULE12: fixed mode: maximum is exact length
// RULE13: length counts sync end to crc
// RULE14: host never programs path value three
// RULE15: byte order bit picks lsb or msb first
module pldmc_framer #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// register port
	input  wire logic [9:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output var  logic [7:0] reg_rdata_out,
	output var  logic       reg_rvalid_out,
	// transmit bytes from the host
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_valid_in,
	output var  logic       tx_ready_out,
	input  wire logic       tx_start_in,
	// modem bit side
	input  wire logic       bit_en_in,
	output var  logic       tx_bit_out,
	output var  logic       tx_active_out,
	input  wire logic       rx_bit_in,
	input  wire logic       preamble_det_in,
	input  wire logic       sync_det_in,
	input  wire logic       carrier_lost_in,
	// receive results
	output var  logic [7:0] rx_data_out,
	output var  logic       rx_valid_out,
	output var  logic       rx_done_out,
	output var  logic       rx_crc_err_out,
	output var  logic [8:0] rx_length_out,
	// raw serial side
	output var  logic       general_pin_four_out,
	output var  logic       rx_data_en_out,
	output var  logic       raw_rx_bit_out
);
	import pldmc_pkg::*;

	logic [7:0] packet_length_control;
	logic [7:0] max_packet_length;
	logic [7:0] next_ctrl;
	logic [7:0] next_max;
	logic [7:0] next_rdata;
	logic       msb_first;
	logic       fixed_length_select;
	logic       crc_en;
	logic [1:0] data_path;
	logic [2:0] len_ofs;
	logic       raw_path;

	assign msb_first           = packet_length_control[BYTE_ORDER_BIT];
	assign fixed_length_select = packet_length_control[FIXED_LEN_BIT];
	assign crc_en              = packet_length_control[CRC_EN_BIT];
	assign data_path           = packet_length_control[PATH_HI:PATH_LO];
	assign len_ofs             = packet_length_control[OFS_HI:0];
	assign raw_path            = (data_path != PATH_PACKET); // RULE6

	////////////////////////////////////////////////////////////////////////////////
	// register port
	always_comb begin
		next_ctrl  = packet_length_control;
		next_max   = max_packet_length;
		next_rdata = reg_rdata_out;
		if (reg_wr_in && reg_addr_in == CTRL_ADDR) begin
			next_ctrl = reg_wdata_in;
		end
		if (reg_wr_in && reg_addr_in == MAXLEN_ADDR) begin
			next_max = reg_wdata_in;
		end
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				CTRL_ADDR:   next_rdata = packet_length_control;
				MAXLEN_ADDR: next_rdata = max_packet_length;
				// wide payloads read back saturated
				RXLEN_ADDR:  next_rdata = rx_length_out[8] ? 8'hff : rx_length_out[7:0];
				default:     next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			packet_length_control <= CTRL_RESET;
			max_packet_length     <= MAXLEN_RESET;
			reg_rdata_out         <= 8'h00;
			reg_rvalid_out        <= 1'b0;
		end else begin
			packet_length_control <= next_ctrl;
			max_packet_length     <= next_max;
			reg_rdata_out         <= next_rdata;
			reg_rvalid_out        <= reg_rd_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit fifo and serialiser
	logic [7:0] fifo_data;
	logic       fifo_valid;
	logic       fifo_pop;

	pldmc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_data_in    (tx_data_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop)
	);

	pldmc_tx_t  tx_st;
	pldmc_tx_t  next_tx_st;
	logic [7:0] tx_shift;
	logic [7:0] next_tx_shift;
	logic [4:0] tx_bits;
	logic [4:0] next_tx_bits;
	logic [7:0] tx_bytes;
	logic [7:0] next_tx_bytes;
	logic [15:0] tx_crc;
	logic [15:0] next_tx_crc;
	logic       next_tx_bit;
	logic       next_tx_active;
	logic       tx_last;

	assign tx_last = !raw_path && tx_bytes == 8'h00;

	always_comb begin
		next_tx_st     = tx_st;
		next_tx_shift  = tx_shift;
		next_tx_bits   = tx_bits;
		next_tx_bytes  = tx_bytes;
		next_tx_crc    = tx_crc;
		next_tx_bit    = tx_bit_out;
		next_tx_active = tx_active_out;
		fifo_pop       = 1'b0;
		unique case (tx_st)
			TX_IDLE: begin
				if (raw_path && fifo_valid) begin
					next_tx_st     = TX_DATA;
					next_tx_bits   = 5'h00;
					next_tx_active = 1'b1;
				end else if (!raw_path && tx_start_in && max_packet_length != 8'h00) begin
					next_tx_st     = TX_DATA;
					next_tx_bits   = 5'h00;
					next_tx_bytes  = max_packet_length; // RULE1 RULE3 RULE12
					next_tx_crc    = CRC_INIT;
					next_tx_active = 1'b1;
				end
			end
			TX_DATA: begin
				if (bit_en_in) begin
					if (tx_bits != 5'h00) begin
						next_tx_bit   = pldmc_first_bit(tx_shift, msb_first); // RULE15
						next_tx_shift = pldmc_shift_out(tx_shift, msb_first);
						next_tx_bits  = tx_bits - 5'h01;
						next_tx_crc   = pldmc_crc_step(tx_crc, next_tx_bit);
					end else if (tx_last) begin
						// crc follows the last data bit with no gap
						if (crc_en) begin
							next_tx_st   = TX_CRC; // RULE4
							next_tx_bit  = tx_crc[15];
							next_tx_crc  = {tx_crc[14:0], 1'b0};
							next_tx_bits = TX_CRC_LEFT;
						end else begin
							next_tx_st     = TX_IDLE; // RULE5
							next_tx_active = 1'b0;
						end
					end else if (fifo_valid) begin
						fifo_pop      = 1'b1;
						next_tx_bit   = pldmc_first_bit(fifo_data, msb_first); // RULE15
						next_tx_shift = pldmc_shift_out(fifo_data, msb_first);
						next_tx_bits  = TX_BYTE_LEFT;
						next_tx_crc   = pldmc_crc_step(tx_crc, next_tx_bit);
						if (!raw_path) begin
							next_tx_bytes = tx_bytes - 8'h01;
						end
					end else if (raw_path) begin
						next_tx_st     = TX_IDLE;
						next_tx_active = 1'b0;
					end
					// packet underrun: hold the line until the host catches up
				end
			end
			TX_CRC: begin
				if (bit_en_in) begin
					if (tx_bits == 5'h00) begin
						next_tx_st     = TX_IDLE;
						next_tx_active = 1'b0;
					end else begin
						next_tx_bit  = tx_crc[15];
						next_tx_crc  = {tx_crc[14:0], 1'b0};
						next_tx_bits = tx_bits - 5'h01;
					end
				end
			end
			default: next_tx_st = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_st         <= TX_IDLE;
			tx_shift      <= 8'h00;
			tx_bits       <= 5'h00;
			tx_bytes      <= 8'h00;
			tx_crc        <= CRC_INIT;
			tx_bit_out    <= 1'b0;
			tx_active_out <= 1'b0;
		end else begin
			tx_st         <= next_tx_st;
			tx_shift      <= next_tx_shift;
			tx_bits       <= next_tx_bits;
			tx_bytes      <= next_tx_bytes;
			tx_crc        <= next_tx_crc;
			tx_bit_out    <= next_tx_bit;
			tx_active_out <= next_tx_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// packet receiver: bytes between sync end and crc start
	pldmc_rx_t  rx_st;
	pldmc_rx_t  next_rx_st;
	logic [7:0] rx_shift;
	logic [7:0] next_rx_shift;
	logic [3:0] rx_cnt;
	logic [3:0] next_rx_cnt;
	logic [7:0] rx_left;
	logic [7:0] next_rx_left;
	logic       rx_first;
	logic       next_rx_first;
	logic [15:0] rx_crc;
	logic [15:0] next_rx_crc;
	logic [7:0] next_rx_data;
	logic       next_rx_valid;
	logic       next_rx_done;
	logic       next_rx_err;
	logic [8:0] next_rx_len;

	always_comb begin
		logic [7:0] byte_v;
		logic [7:0] total_v;
		byte_v        = pldmc_shift_in(rx_shift, rx_bit_in, msb_first); // RULE15
		total_v       = pldmc_total(byte_v, len_ofs, max_packet_length);
		next_rx_st    = rx_st;
		next_rx_shift = rx_shift;
		next_rx_cnt   = rx_cnt;
		next_rx_left  = rx_left;
		next_rx_first = rx_first;
		next_rx_crc   = rx_crc;
		next_rx_data  = rx_data_out;
		next_rx_len   = rx_length_out;
		next_rx_valid = 1'b0;
		next_rx_done  = 1'b0;
		next_rx_err   = 1'b0;
		unique case (rx_st)
			RX_IDLE: begin
				if (!raw_path && sync_det_in &&
						(!fixed_length_select || max_packet_length != 8'h00)) begin
					next_rx_st    = RX_DATA;
					next_rx_cnt   = 4'h0;
					next_rx_first = 1'b1;
					next_rx_crc   = CRC_INIT;
					next_rx_left  = max_packet_length; // RULE1 RULE12
					if (fixed_length_select) begin
						next_rx_len = {1'b0, max_packet_length};
					end
				end
			end
			RX_DATA: begin
				if (bit_en_in) begin
					next_rx_shift = byte_v;
					next_rx_crc   = pldmc_crc_step(rx_crc, rx_bit_in);
					next_rx_cnt   = rx_cnt + 4'h1;
					if (rx_cnt == RX_BYTE_LAST) begin
						next_rx_cnt   = 4'h0;
						next_rx_data  = byte_v;
						next_rx_valid = 1'b1; // RULE13
						next_rx_first = 1'b0;
						if (rx_first && !fixed_length_select) begin
							// RULE2 RULE9 RULE11
							next_rx_left = (total_v == 8'h00) ? 8'h00 : total_v - 8'h01;
							next_rx_len  = pldmc_payload(byte_v, len_ofs); // RULE10
						end else begin
							next_rx_left = rx_left - 8'h01;
						end
						if (next_rx_left == 8'h00) begin
							if (crc_en) begin
								next_rx_st = RX_CRC; // RULE4
							end else begin
								next_rx_st   = RX_IDLE; // RULE5
								next_rx_done = 1'b1;
							end
						end
					end
				end
			end
			RX_CRC: begin
				// running the crc over its own bits leaves zero when intact
				if (bit_en_in) begin
					next_rx_crc = pldmc_crc_step(rx_crc, rx_bit_in);
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == RX_CRC_LAST) begin
						next_rx_st   = RX_IDLE;
						next_rx_done = 1'b1;
						next_rx_err  = (next_rx_crc != 16'h0000); // RULE4
					end
				end
			end
			default: next_rx_st = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_st          <= RX_IDLE;
			rx_shift       <= 8'h00;
			rx_cnt         <= 4'h0;
			rx_left        <= 8'h00;
			rx_first       <= 1'b0;
			rx_crc         <= CRC_INIT;
			rx_data_out    <= 8'h00;
			rx_valid_out   <= 1'b0;
			rx_done_out    <= 1'b0;
			rx_crc_err_out <= 1'b0;
			rx_length_out  <= 9'h000;
		end else begin
			rx_st          <= next_rx_st;
			rx_shift       <= next_rx_shift;
			rx_cnt         <= next_rx_cnt;
			rx_left        <= next_rx_left;
			rx_first       <= next_rx_first;
			rx_crc         <= next_rx_crc;
			rx_data_out    <= next_rx_data;
			rx_valid_out   <= next_rx_valid;
			rx_done_out    <= next_rx_done;
			rx_crc_err_out <= next_rx_err;
			rx_length_out  <= next_rx_len;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// raw serial path: interrupt pin and receive data gate
	logic next_pin_four;
	logic next_data_en;
	logic next_raw_bit;

	always_comb begin
		next_pin_four = ((data_path == PATH_RAW_PRE) && preamble_det_in) || // RULE7
			((data_path == PATH_RAW_SYNC) && sync_det_in); // RULE8
		next_data_en  = rx_data_en_out;
		// a fresh preamble outranks a carrier drop in the same cycle
		if (!raw_path) begin
			next_data_en = 1'b0;
		end else if (preamble_det_in) begin
			next_data_en = 1'b1; // RULE7 RULE8
		end else if (carrier_lost_in) begin
			next_data_en = 1'b0;
		end
		next_raw_bit = (rx_data_en_out && bit_en_in) ? rx_bit_in : raw_rx_bit_out;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			general_pin_four_out <= 1'b0;
			rx_data_en_out       <= 1'b0;
			raw_rx_bit_out       <= 1'b0;
		end else begin
			general_pin_four_out <= next_pin_four;
			rx_data_en_out       <= next_data_en;
			raw_rx_bit_out       <= next_raw_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_tx_start;
		tx_st == TX_IDLE && !raw_path && tx_start_in && max_packet_length != 8'h00;
	endsequence
	sequence s_tx_end;
		tx_st == TX_DATA && bit_en_in && tx_bits == 5'h00 && tx_last;
	endsequence
	sequence s_len_byte;
		rx_st == RX_DATA && bit_en_in && rx_cnt == RX_BYTE_LAST && rx_first
			&& !fixed_length_select;
	endsequence

	property p_fixed_tx;
		s_tx_start ##0 fixed_length_select[*1] |=> tx_bytes == $past(max_packet_length);
	endproperty
	a_fixed_tx: assert property (p_fixed_tx) else $error("fixed tx length wrong"); // RULE1
	property p_var_tx;
		s_tx_start ##0 !fixed_length_select |=> tx_active_out && tx_bytes == $past(max_packet_length);
	endproperty
	a_var_tx: assert property (p_var_tx) else $error("variable tx length wrong"); // RULE3
	property p_var_rx_left;
		s_len_byte |=> rx_valid_out && (rx_left == ((pldmc_total(rx_data_out, len_ofs,
			max_packet_length) == 8'h00) ? 8'h00 : pldmc_total(rx_data_out, len_ofs,
			max_packet_length) - 8'h01));
	endproperty
	a_var_rx_left: assert property (p_var_rx_left) else $error("rx byte count wrong"); // RULE9
	property p_payload;
		s_len_byte |=> rx_length_out == pldmc_payload(rx_data_out, len_ofs);
	endproperty
	a_payload: assert property (p_payload) else $error("payload length wrong"); // RULE10
	property p_crc_on;
		s_tx_end ##0 crc_en |=> tx_st == TX_CRC && tx_active_out ##1 tx_active_out;
	endproperty
	a_crc_on: assert property (p_crc_on) else $error("crc not appended"); // RULE4
	property p_crc_off;
		s_tx_end ##0 !crc_en |=> tx_st == TX_IDLE && !tx_active_out;
	endproperty
	a_crc_off: assert property (p_crc_off) else $error("crc sent while disabled"); // RULE5
	property p_pin_pre;
		data_path == PATH_RAW_PRE && preamble_det_in
			|=> general_pin_four_out && rx_data_en_out;
	endproperty
	a_pin_pre: assert property (p_pin_pre) else $error("preamble interrupt missing"); // RULE7
	property p_pin_sync;
		data_path == PATH_RAW_SYNC && sync_det_in |=> general_pin_four_out;
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("sync interrupt missing"); // RULE8
	property p_packet_quiet;
		data_path == PATH_PACKET |=> !general_pin_four_out && !rx_data_en_out;
	endproperty
	a_packet_quiet: assert property (p_packet_quiet) else $error("raw path in packet mode"); // RULE6
	property p_order;
		tx_st == TX_DATA && bit_en_in && fifo_pop
			|=> tx_bit_out == ($past(msb_first) ? $past(fifo_data[7]) : $past(fifo_data[0]));
	endproperty
	a_order: assert property (p_order) else $error("bit order wrong"); // RULE15
endmodule
`default_nettype wire

// ==== pldmc_modem.sv ====
// modem model: bit rate enable and tx to rx loopback
`timescale 1ns/1ps
`default_nettype none
module pldmc_modem (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// link
	input  wire logic tx_bit_in,
	input  wire logic flip_in,
	output logic      bit_en_out,
	output logic      rx_bit_out
);
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	always_comb begin
		next_cnt = sys_rst_in ? 2'h0 : cnt + 2'h1;
	end
	always_ff @(posedge clk_in) begin
		cnt <= next_cnt;
	end
	// one bit every fourth clock; inversion lets a bench corrupt a frame
	assign bit_en_out = (cnt == 2'h3);
	assign rx_bit_out = tx_bit_in ^ flip_in;
endmodule
`default_nettype wire

// ==== packet_length_and_data_mode_control_tb.sv ====
// self-checking bench: registers, fifo, framing and raw serial path
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	$display("ERROR %s exp %0h got %0h", nm, ex, got); err_count++; end end
module packet_length_and_data_mode_control_tb;
	import pldmc_pkg::*;
	logic clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, tx_valid_in = 0;
	logic [9:0] reg_addr_in = 10'h000;
	logic [7:0] reg_wdata_in = 8'h00, tx_data_in = 8'h00, reg_rdata_out, rx_data_out, sh;
	logic tx_start_in = 0, preamble_det_in = 0, sync_det_in = 0, carrier_lost_in = 0;
	logic flip = 0, bit_en_in, rx_bit_in, tx_bit_out, tx_active_out, tx_ready_out, be_d;
	logic reg_rvalid_out, rx_valid_out, rx_done_out, rx_crc_err_out, crc_bad, done_seen;
	logic general_pin_four_out, rx_data_en_out, raw_rx_bit_out;
	logic [8:0] rx_length_out;
	logic [7:0] rxq[$];
	int err_count = 0, samples_checked = 0, bitcnt, k, n;
	pldmc_framer #(.FIFO_DEPTH(16)) u_pldmc_framer (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
		.tx_ready_out(tx_ready_out), .tx_start_in(tx_start_in), .bit_en_in(bit_en_in),
		.tx_bit_out(tx_bit_out), .tx_active_out(tx_active_out), .rx_bit_in(rx_bit_in),
		.preamble_det_in(preamble_det_in), .sync_det_in(sync_det_in),
		.carrier_lost_in(carrier_lost_in), .rx_data_out(rx_data_out),
		.rx_valid_out(rx_valid_out), .rx_done_out(rx_done_out),
		.rx_crc_err_out(rx_crc_err_out), .rx_length_out(rx_length_out),
		.general_pin_four_out(general_pin_four_out), .rx_data_en_out(rx_data_en_out),
		.raw_rx_bit_out(raw_rx_bit_out));
	pldmc_modem u_pldmc_modem (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.tx_bit_in(tx_bit_out), .flip_in(flip), .bit_en_out(bit_en_in),
		.rx_bit_out(rx_bit_in));
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	// wire bits gathered lsb first, one cycle after each bit enable
	always @(posedge clk_in) begin
		be_d <= bit_en_in;
		if (be_d && tx_active_out) sh <= {tx_bit_out, sh[7:1]};
		if (bit_en_in && tx_active_out) bitcnt++;
		if (rx_valid_out) rxq.push_back(rx_data_out);
		if (rx_done_out) begin
			done_seen = 1;
			crc_bad = rx_crc_err_out;
		end
	end
	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1;
		@(posedge clk_in);
		reg_wr_in <= 0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] ex);
		@(posedge clk_in);
		reg_addr_in <= a; reg_rd_in <= 1;
		@(posedge clk_in);
		reg_rd_in <= 0;
		@(posedge clk_in);
		`CHK("rvalid", 1'b1, reg_rvalid_out)
		`CHK("rdata", ex, reg_rdata_out)
	endtask
	task automatic push(input logic [7:0] b);
		@(posedge clk_in);
		tx_valid_in <= 1; tx_data_in <= b; k = 0;
		do begin @(posedge clk_in); k++; end while (!tx_ready_out && k < 50);
		tx_valid_in <= 0;
		if (!tx_ready_out) begin err_count++; give_verdict(); end
	endtask
	// which: 0 preamble, 1 sync, otherwise carrier lost
	task automatic pulse(input int which, input logic ex);
		@(posedge clk_in);
		if (which == 0) preamble_det_in <= 1;
		else if (which == 1) sync_det_in <= 1;
		else carrier_lost_in <= 1;
		@(posedge clk_in);
		preamble_det_in <= 0;
		sync_det_in <= 0;
		carrier_lost_in <= 0;
		@(posedge clk_in);
		`CHK("pin four", ex, general_pin_four_out)
	endtask
	// transmit with loopback; sync follows the first bit enable of the frame
	task automatic run(input int bits);
		rxq.delete(); done_seen = 0; bitcnt = 0; k = 0;
		@(posedge clk_in);
		tx_start_in <= 1;
		@(posedge clk_in);
		tx_start_in <= 0;
		do begin @(posedge clk_in); k++; end while (!(bit_en_in && tx_active_out) && k < 100);
		if (!(bit_en_in && tx_active_out)) begin err_count++; give_verdict(); end
		sync_det_in <= 1;
		@(posedge clk_in);
		sync_det_in <= 0;
		while ((!done_seen || tx_active_out) && k < 5000) begin @(posedge clk_in); k++; end
		if (k >= 5000) begin err_count++; give_verdict(); end
		`CHK("bits", bits, bitcnt)
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 0;
		rd(CTRL_ADDR, CTRL_RESET);
		rd(MAXLEN_ADDR, MAXLEN_RESET);
		rd(10'h100, 8'h00);
		`CHK("ready", 1'b1, tx_ready_out)
		// fill the fifo until refused, then send it as one fixed frame
		wr(CTRL_ADDR, 8'h60);
		wr(MAXLEN_ADDR, 8'h10);
		@(posedge clk_in);
		tx_valid_in <= 1; n = 0;
		repeat (24) begin
			@(posedge clk_in);
			if (tx_ready_out && tx_valid_in) begin n++; tx_data_in <= 8'(n); end
		end
		tx_valid_in <= 0;
		`CHK("fill", 16, n)
		run(16 * 8 + 16 + 1);
		for (int i = 0; i < 16; i++) `CHK("fixed byte", 8'(i), rxq[i])
		`CHK("crc ok", 1'b0, crc_bad)
		`CHK("fixed len", 9'h010, rx_length_out)
		// variable length, offset 2, capped by maximum, no crc
		wr(CTRL_ADDR, 8'h02);
		wr(MAXLEN_ADDR, 8'h04);
		push(8'h05); push(8'haa); push(8'h55); push(8'h3c);
		run(4 * 8 + 1);
		`CHK("var count", 4, rxq.size())
		`CHK("var len", 9'h003, rx_length_out)
		`CHK("no crc err", 1'b0, crc_bad)
		rd(RXLEN_ADDR, 8'h03);
		// byte order on the wire, both settings
		for (int m = 0; m < 2; m++) begin
			wr(CTRL_ADDR, m ? 8'hc0 : 8'h40);
			wr(MAXLEN_ADDR, 8'h01);
			push(8'h1e);
			run(9);
			`CHK("wire", m ? 8'h78 : 8'h1e, sh)
			`CHK("order", 8'h1e, rxq[0])
		end
		// corrupted frame must fail its check
		wr(CTRL_ADDR, 8'h60);
		wr(MAXLEN_ADDR, 8'h02);
		push(8'h81); push(8'h42);
		flip <= 1;
		run(2 * 8 + 16 + 1);
		flip <= 0;
		`CHK("crc err", 1'b1, crc_bad)
		// data path modes; value three is never programmed
		for (int p = 0; p < 3; p++) begin
			wr(CTRL_ADDR, 8'(p << 3));
			pulse(0, p == 1);
			if (p != 0) pulse(1, p == 2);
			if (p == 1) begin
				// one raw byte streams with no length or crc and loops back
				bitcnt = 0;
				push(8'h80);
				k = 0;
				do begin @(posedge clk_in); k++; end while ((k < 4 || tx_active_out) && k < 200);
				if (k >= 200) begin err_count++; give_verdict(); end
				`CHK("raw bits", 9, bitcnt)
				`CHK("raw rx bit", 1'b1, raw_rx_bit_out)
			end
			`CHK("data en", p != 0, rx_data_en_out)
			pulse(2, 1'b0);
			`CHK("data off", 1'b0, rx_data_en_out)
		end
		give_verdict();
	end
endmodule
`default_nettype wire
